// file: src/drive_power_state_machine.sv
`timescale 1ns/1ps
module drive_power_state_machine
  import drive_psm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Object access
  input wire logic i_obj_wr,
  input wire logic i_obj_rd,
  input wire logic [15:0] i_obj_index,
  input wire logic [15:0] i_obj_wdata,
  output logic [15:0] o_obj_rdata,
  output logic o_obj_ack,
  output logic o_obj_error,
  // Drive events
  input wire logic i_self_test_ok,
  input wire logic i_unrecoverable_error,
  input wire logic i_fault,
  input wire logic [15:0] i_fault_code,
  input wire logic i_limit_switch,
  input wire logic i_standstill,
  // Power stage and motion
  output logic o_power_stage_on,
  output ramp_kind_t o_ramp_kind,
  output logic o_halt_active,
  output logic [15:0] o_state_word,
  output logic [7:0] o_mode_display
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] cmd_q;
  logic [15:0] cmd_prev_q;
  logic [15:0] qs_code_q;
  logic [15:0] sd_code_q;
  logic [15:0] do_code_q;
  logic [15:0] halt_code_q;
  logic [15:0] fault_cfg_q;
  logic [15:0] err_code_q;
  logic [7:0] mode_sel_q;
  logic [7:0] mode_disp_q;
  logic [15:0] state_word_q;
  logic [15:0] rdata_q;
  logic ack_q;
  logic err_q;
  logic lock_q;
  logic qs_hold_q;
  logic power_q;
  logic halt_q;
  ramp_kind_t ramp_kind_q;
  psm_state_t state_q;
  psm_state_t state_d;
  psm_state_t target_q;
  psm_state_t target_d;
  logic start;
  ramp_kind_t start_kind;
  logic abort;
  logic braking;
  ramp_kind_t brake_kind;
  logic ramp_done;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic c_shutdown;
  logic c_switch_on;
  logic c_disable_volt;
  logic c_quick_stop;
  logic c_enable_op;
  logic fault_reset_rise;
  logic qs_release_rise;
  logic quiet;
  logic halt_mode;
  logic qs_hold_code;

  // Bit 7 set blocks every level-coded state command; the halt bit still acts
  assign c_shutdown = !cmd_q[CW_FAULT_RESET] && cmd_q[CW_QUICK_STOP_N] && cmd_q[CW_ENABLE_VOLT]
                      && !cmd_q[CW_SWITCH_ON];
  assign c_switch_on = !cmd_q[CW_FAULT_RESET] && !cmd_q[CW_ENABLE_OP] && cmd_q[CW_QUICK_STOP_N]
                       && cmd_q[CW_ENABLE_VOLT] && cmd_q[CW_SWITCH_ON];
  assign c_enable_op = !cmd_q[CW_FAULT_RESET] && cmd_q[CW_ENABLE_OP] && cmd_q[CW_QUICK_STOP_N]
                       && cmd_q[CW_ENABLE_VOLT] && cmd_q[CW_SWITCH_ON];
  assign c_disable_volt = !cmd_q[CW_FAULT_RESET] && !cmd_q[CW_ENABLE_VOLT];
  assign c_quick_stop = !cmd_q[CW_FAULT_RESET] && !cmd_q[CW_QUICK_STOP_N] && cmd_q[CW_ENABLE_VOLT];
  assign fault_reset_rise = cmd_q[CW_FAULT_RESET] && !cmd_prev_q[CW_FAULT_RESET];
  assign qs_release_rise = c_enable_op && !cmd_prev_q[CW_QUICK_STOP_N];
  assign quiet = !lock_q && !i_unrecoverable_error && !i_fault;
  assign halt_mode = (mode_disp_q == MODE_PROFILE_POS) || (mode_disp_q == MODE_VELOCITY)
                     || (mode_disp_q == MODE_PROFILE_VEL) || (mode_disp_q == MODE_PROFILE_TORQUE)
                     || (mode_disp_q == MODE_INTERPOLATED);
  assign qs_hold_code = (qs_code_q == CODE_SLOW_HOLD) || (qs_code_q == CODE_QUICK_HOLD);

  // Reserved codes fall back to a stop without ramp
  function automatic ramp_kind_t react_kind(input logic [15:0] code);
    ramp_kind_t k;
    k = RAMP_NONE;
    if ((code == CODE_SLOW) || (code == CODE_SLOW_HOLD)) begin
      k = RAMP_SLOW;
    end else if ((code == CODE_QUICK) || (code == CODE_QUICK_HOLD)) begin
      k = RAMP_QUICK;
    end
    return k;
  endfunction : react_kind

  function automatic logic [15:0] word_of(input psm_state_t s);
    logic [15:0] w;
    w = SW_NOT_READY;
    unique case (s)
      ST_NOT_READY: w = SW_NOT_READY;
      ST_SOD: w = SW_SWITCH_ON_DISABLED;
      ST_READY: w = SW_READY;
      ST_SWITCHED_ON: w = SW_SWITCHED_ON;
      ST_OP: w = SW_OP_ENABLED;
      ST_QS: w = SW_QUICK_STOP;
      ST_FR: w = SW_FAULT_REACTION;
      ST_FAULT: w = SW_FAULT;
      default: w = SW_NOT_READY;
    endcase
    return w;
  endfunction : word_of

  // ----------------------------------------------------------------
  // Transition logic
  // ----------------------------------------------------------------
  // Patterns with no transition from the present state fall through unchanged
  always_comb begin
    state_d = state_q;
    target_d = target_q;
    start = 1'b0;
    start_kind = RAMP_NONE;
    abort = 1'b0;
    if (lock_q || i_unrecoverable_error) begin
      state_d = ST_NOT_READY;
      abort = 1'b1;
    end else if (i_fault && (state_q != ST_FR) && (state_q != ST_FAULT) && (state_q != ST_NOT_READY)) begin
      state_d = ST_FR;
      start = 1'b1;
      start_kind = react_kind(fault_cfg_q);
    end else begin
      unique case (state_q)
        ST_NOT_READY: begin
          if (i_self_test_ok) state_d = ST_SOD;
        end
        ST_SOD: begin
          if (c_shutdown) state_d = ST_READY;
        end
        ST_READY: begin
          if (c_switch_on) state_d = ST_SWITCHED_ON;
          else if (c_disable_volt || c_quick_stop) state_d = ST_SOD;
        end
        ST_SWITCHED_ON: begin
          if (c_enable_op) state_d = ST_OP;
          else if (c_shutdown) state_d = ST_READY;
          else if (c_disable_volt || c_quick_stop) state_d = ST_SOD;
        end
        ST_OP: begin
          if (ramp_done) begin
            state_d = target_q;
          end else if (braking) begin
            state_d = ST_OP;
          end else if (c_disable_volt) begin
            state_d = ST_SOD;
          end else if (c_quick_stop || i_limit_switch) begin
            state_d = ST_QS;
            start = 1'b1;
            start_kind = react_kind(qs_code_q);
          end else if (c_shutdown) begin
            if (react_kind(sd_code_q) == RAMP_NONE) begin
              state_d = ST_READY;
            end else begin
              start = 1'b1;
              start_kind = react_kind(sd_code_q);
              target_d = ST_READY;
            end
          end else if (c_switch_on) begin
            if (react_kind(do_code_q) == RAMP_NONE) begin
              state_d = ST_SWITCHED_ON;
            end else begin
              start = 1'b1;
              start_kind = react_kind(do_code_q);
              target_d = ST_SWITCHED_ON;
            end
          end
        end
        ST_QS: begin
          if (c_disable_volt) begin
            state_d = ST_SOD;
            abort = 1'b1;
          end else if (ramp_done) begin
            if (!qs_hold_q) state_d = ST_SOD;
          end else if (!braking && qs_hold_q && qs_release_rise) begin
            state_d = ST_OP;
          end
        end
        ST_FR: begin
          if (ramp_done) state_d = ST_FAULT;
        end
        ST_FAULT: begin
          if (fault_reset_rise) state_d = ST_SOD;
        end
        default: begin
          state_d = ST_NOT_READY;
        end
      endcase
    end
  end

  stop_ramp_seq u_stop (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_start(start),
    .i_kind(start_kind),
    .i_abort(abort),
    .i_standstill(i_standstill),
    .o_braking(braking),
    .o_kind(brake_kind),
    .o_done(ramp_done)
  );

  // ----------------------------------------------------------------
  // State and state word
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_q <= ST_NOT_READY;
      target_q <= ST_SOD;
      state_word_q <= SW_NOT_READY;
      lock_q <= 1'b0;
      qs_hold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      target_q <= target_d;
      state_word_q <= word_of(state_d);
      lock_q <= lock_q || i_unrecoverable_error;
      if ((state_d == ST_QS) && (state_q != ST_QS)) qs_hold_q <= qs_hold_code;
    end
  end

  // ----------------------------------------------------------------
  // Power stage, ramp and halt
  // ----------------------------------------------------------------
  // Hold codes keep the motor energized in quick stop; no-ramp paths drop it at once, except quick stop with code 0 or a reserved code, one cycle later
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      power_q <= 1'b0;
      halt_q <= 1'b0;
      ramp_kind_q <= RAMP_NONE;
    end else begin
      power_q <= (state_d == ST_OP) || (state_d == ST_QS)
                 || ((state_d == ST_FR) && (start ? (start_kind != RAMP_NONE) : braking));
      halt_q <= (state_d == ST_OP) && cmd_q[CW_HALT] && halt_mode && !start && !braking
                && ((halt_code_q == CODE_SLOW) || (halt_code_q == CODE_QUICK));
      if (start) ramp_kind_q <= start_kind;
      else if (braking) ramp_kind_q <= brake_kind;
      else if ((state_d == ST_OP) && cmd_q[CW_HALT] && halt_mode) ramp_kind_q <= react_kind(halt_code_q);
      else ramp_kind_q <= RAMP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Object access
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      cmd_q <= COMMAND_RESET;
      qs_code_q <= QS_CODE_RESET;
      sd_code_q <= SD_CODE_RESET;
      do_code_q <= DO_CODE_RESET;
      halt_code_q <= HALT_CODE_RESET;
      fault_cfg_q <= FAULT_CODE_RESET;
      mode_sel_q <= MODE_RESET;
    end else if (i_obj_wr) begin
      unique case (i_obj_index)
        IDX_COMMAND: cmd_q <= i_obj_wdata;
        IDX_QS_CODE: qs_code_q <= i_obj_wdata;
        IDX_SD_CODE: sd_code_q <= i_obj_wdata;
        IDX_DO_CODE: do_code_q <= i_obj_wdata;
        IDX_HALT_CODE: halt_code_q <= i_obj_wdata;
        IDX_FAULT_CODE: fault_cfg_q <= i_obj_wdata;
        IDX_MODE_SEL: mode_sel_q <= i_obj_wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      cmd_prev_q <= COMMAND_RESET;
      mode_disp_q <= MODE_RESET;
      err_code_q <= ERROR_CODE_RESET;
    end else begin
      cmd_prev_q <= cmd_q;
      mode_disp_q <= mode_sel_q;
      if ((state_d == ST_FR) && (state_q != ST_FR)) err_code_q <= i_fault_code;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= i_obj_wr || i_obj_rd;
      err_q <= 1'b0;
      if (i_obj_rd) begin
        unique case (i_obj_index)
          IDX_COMMAND: rdata_q <= cmd_q;
          IDX_STATE: rdata_q <= state_word_q;
          IDX_QS_CODE: rdata_q <= qs_code_q;
          IDX_SD_CODE: rdata_q <= sd_code_q;
          IDX_DO_CODE: rdata_q <= do_code_q;
          IDX_HALT_CODE: rdata_q <= halt_code_q;
          IDX_FAULT_CODE: rdata_q <= fault_cfg_q;
          IDX_MODE_SEL: rdata_q <= {8'h00, mode_sel_q};
          IDX_MODE_DISP: rdata_q <= {8'h00, mode_disp_q};
          IDX_ERROR_CODE: rdata_q <= err_code_q;
          default: begin
            rdata_q <= 16'h0000;
            err_q <= 1'b1;
          end
        endcase
      end else if (i_obj_wr) begin
        err_q <= (i_obj_index == IDX_STATE) || (i_obj_index == IDX_MODE_DISP) || (i_obj_index == IDX_ERROR_CODE)
                 || !((i_obj_index == IDX_COMMAND) || (i_obj_index == IDX_QS_CODE) || (i_obj_index == IDX_SD_CODE)
                 || (i_obj_index == IDX_DO_CODE) || (i_obj_index == IDX_HALT_CODE)
                 || (i_obj_index == IDX_FAULT_CODE) || (i_obj_index == IDX_MODE_SEL));
      end
    end
  end

  assign o_obj_rdata = rdata_q;
  assign o_obj_ack = ack_q;
  assign o_obj_error = err_q;
  assign o_power_stage_on = power_q;
  assign o_ramp_kind = ramp_kind_q;
  assign o_halt_active = halt_q;
  assign o_state_word = state_word_q;
  assign o_mode_display = mode_disp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_enter_qs;
    state_q == ST_QS;
  endsequence

  sequence s_leave_to_sod;
    state_q == ST_SOD;
  endsequence

  a_selftest_to_sod: assert property (state_q == ST_NOT_READY && quiet && i_self_test_ok |=> state_q == ST_SOD)
    else $error("self-test pass did not reach switch-on disabled");
  a_unrec_sticky: assert property (i_unrecoverable_error |=> (state_q == ST_NOT_READY)[*3])
    else $error("unrecoverable error did not hold not-ready");
  a_shutdown_ready: assert property (state_q == ST_SOD && quiet && c_shutdown |=> state_q == ST_READY)
    else $error("shutdown did not reach ready");
  a_dvolt_disable: assert property (state_q == ST_READY && quiet && c_disable_volt |=> state_q == ST_SOD)
    else $error("disable voltage did not reach switch-on disabled");
  a_reset_edge_only: assert property (state_q == ST_FAULT && !lock_q && !i_unrecoverable_error
    && cmd_q[CW_FAULT_RESET] && cmd_prev_q[CW_FAULT_RESET] |=> state_q == ST_FAULT)
    else $error("fault reset acted on a level");
  a_qs_immediate: assert property (state_q == ST_OP && quiet && !braking && !ramp_done && c_quick_stop
    && qs_code_q == CODE_NO_RAMP ##0 (quiet && !c_disable_volt)[*2] |-> s_enter_qs ##1 s_leave_to_sod)
    else $error("quick stop code 0 did not end in switch-on disabled");
  a_qs_hold_return: assert property (state_q == ST_QS && quiet && qs_hold_q && !braking && !ramp_done
    && qs_release_rise |=> state_q == ST_OP)
    else $error("return from held quick stop failed");
  a_limit_to_qs: assert property (state_q == ST_OP && quiet && !braking && !ramp_done && !c_disable_volt
    && i_limit_switch |=> s_enter_qs)
    else $error("limit switch did not enter quick stop");
  a_mode_display: assert property (1'b1 |=> mode_disp_q == $past(mode_sel_q))
    else $error("mode display did not follow select");
  a_error_stored: assert property ($rose(state_q == ST_FR) |-> err_code_q == $past(i_fault_code))
    else $error("fault error code not stored");
  a_word_tracks: assert property (state_word_q == word_of(state_q))
    else $error("state word out of step with state");

endmodule : drive_power_state_machine

// file: common/drive_psm_pkg.sv
package drive_psm_pkg;

  // ----------------------------------------------------------------
  // Object indexes
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_COMMAND = 16'h6040;
  localparam logic [15:0] IDX_STATE = 16'h6041;
  localparam logic [15:0] IDX_QS_CODE = 16'h605A;
  localparam logic [15:0] IDX_SD_CODE = 16'h605B;
  localparam logic [15:0] IDX_DO_CODE = 16'h605C;
  localparam logic [15:0] IDX_HALT_CODE = 16'h605D;
  localparam logic [15:0] IDX_FAULT_CODE = 16'h605E;
  localparam logic [15:0] IDX_MODE_SEL = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISP = 16'h6061;
  localparam logic [15:0] IDX_ERROR_CODE = 16'h1003;

  // ----------------------------------------------------------------
  // Command word bit positions
  // ----------------------------------------------------------------
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_ENABLE_VOLT = 1;
  localparam int CW_QUICK_STOP_N = 2;
  localparam int CW_ENABLE_OP = 3;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT = 8;

  // ----------------------------------------------------------------
  // State word values
  // ----------------------------------------------------------------
  localparam logic [15:0] SW_NOT_READY = 16'h0000;
  localparam logic [15:0] SW_SWITCH_ON_DISABLED = 16'h0040;
  localparam logic [15:0] SW_READY = 16'h0021;
  localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
  localparam logic [15:0] SW_OP_ENABLED = 16'h0027;
  localparam logic [15:0] SW_QUICK_STOP = 16'h0007;
  localparam logic [15:0] SW_FAULT_REACTION = 16'h000F;
  localparam logic [15:0] SW_FAULT = 16'h0008;

  // ----------------------------------------------------------------
  // Reaction codes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_NO_RAMP = 16'h0000;
  localparam logic [15:0] CODE_SLOW = 16'h0001;
  localparam logic [15:0] CODE_QUICK = 16'h0002;
  localparam logic [15:0] CODE_SLOW_HOLD = 16'h0005;
  localparam logic [15:0] CODE_QUICK_HOLD = 16'h0006;
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] QS_CODE_RESET = 16'h0002;
  localparam logic [15:0] SD_CODE_RESET = 16'h0001;
  localparam logic [15:0] DO_CODE_RESET = 16'h0001;
  localparam logic [15:0] HALT_CODE_RESET = 16'h0001;
  localparam logic [15:0] FAULT_CODE_RESET = 16'h0002;
  localparam logic [15:0] ERROR_CODE_RESET = 16'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Modes in which halt acts
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_VELOCITY = 8'h02;
  localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
  localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
  localparam logic [7:0] MODE_INTERPOLATED = 8'h07;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RAMP_NONE = 2'h0,
    RAMP_SLOW = 2'h1,
    RAMP_QUICK = 2'h2
  } ramp_kind_t;

  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_SOD = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED_ON = 8'h08,
    ST_OP = 8'h10,
    ST_QS = 8'h20,
    ST_FR = 8'h40,
    ST_FAULT = 8'h80
  } psm_state_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'h1,
    SR_BRAKE = 2'h2
  } stop_state_t;

endpackage : drive_psm_pkg

// file: src/stop_ramp_seq.sv
`timescale 1ns/1ps
module stop_ramp_seq
  import drive_psm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Request
  input wire logic i_start,
  input wire ramp_kind_t i_kind,
  input wire logic i_abort,
  // Motor feedback
  input wire logic i_standstill,
  // Status
  output logic o_braking,
  output ramp_kind_t o_kind,
  output logic o_done
);

  stop_state_t state_q;
  ramp_kind_t kind_q;
  logic done_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A new start wins over a running ramp, so a fault can retarget a stop
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_q <= SR_IDLE;
      kind_q <= RAMP_NONE;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_abort) begin
        state_q <= SR_IDLE;
        kind_q <= RAMP_NONE;
      end else if (i_start) begin
        kind_q <= i_kind;
        if (i_kind == RAMP_NONE) begin
          state_q <= SR_IDLE;
          done_q <= 1'b1;
        end else begin
          state_q <= SR_BRAKE;
        end
      end else begin
        unique case (state_q)
          SR_IDLE: begin
            kind_q <= RAMP_NONE;
          end
          SR_BRAKE: begin
            if (i_standstill) begin
              state_q <= SR_IDLE;
              done_q <= 1'b1;
            end
          end
          default: begin
            state_q <= SR_IDLE;
          end
        endcase
      end
    end
  end

  assign o_braking = (state_q == SR_BRAKE);
  assign o_kind = kind_q;
  assign o_done = done_q;

endmodule : stop_ramp_seq

// file: testbench/drive_master.sv
`timescale 1ns/1ps
module drive_master (
  // Clock and answer
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic i_error,
  input wire logic [15:0] i_rdata,
  // Request
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [15:0] o_index = 16'h0000,
  output logic [15:0] o_wdata = 16'h0000
);
  logic [15:0] rdata_q;
  logic err_q;
  // Each call makes one read or write access at any object index
  task automatic access(input logic rd, input logic [15:0] idx, input logic [15:0] data);
    int n;
    n = 0;
    @(posedge i_clock);
    o_rd <= rd;
    o_wr <= !rd;
    o_index <= idx;
    o_wdata <= data;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    // Strobe is a single pulse; index held until ack is sampled
    do begin
      @(posedge i_clock);
      n++;
    end while (i_ack !== 1'b1 && n < 4);
    // A missing answer counts against the run
    if (i_ack !== 1'b1) tb.n_mismatch++;
    rdata_q = i_rdata;
    err_q = i_error;
  endtask : access
endmodule : drive_master

// file: testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb;
  import drive_psm_pkg::*;
  typedef struct {logic [15:0] cw; logic [15:0] sw;} row_t;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic ok = 1'b0, unrec = 1'b0, flt = 1'b0, lim = 1'b0, still = 1'b1;
  logic wr, rd, ack, err, pwr, halt;
  logic [15:0] idx, wd, rdat, sw;
  logic [7:0] md;
  ramp_kind_t rk;
  int n_mismatch = 0;
  int checks_done = 0;
  row_t rows[15] = '{'{16'h0006, SW_READY}, '{16'h0007, SW_SWITCHED_ON}, '{16'h000F, SW_OP_ENABLED},
    '{16'h0007, SW_SWITCHED_ON}, '{16'h000F, SW_OP_ENABLED}, '{16'h0006, SW_READY},
    '{16'h0007, SW_SWITCHED_ON}, '{16'h0000, SW_SWITCH_ON_DISABLED}, '{16'h000F, SW_SWITCH_ON_DISABLED},
    '{16'h0006, SW_READY}, '{16'h0002, SW_SWITCH_ON_DISABLED}, '{16'h0006, SW_READY},
    '{16'h0007, SW_SWITCHED_ON}, '{16'h000F, SW_OP_ENABLED}, '{16'h000B, SW_SWITCH_ON_DISABLED}};
  always #2.5 i_clock = ~i_clock;
  drive_master drive_master_i (.i_clock(i_clock), .i_ack(ack), .i_error(err), .i_rdata(rdat),
    .o_wr(wr), .o_rd(rd), .o_index(idx), .o_wdata(wd));
  drive_power_state_machine drive_power_state_machine_i (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_obj_wr(wr), .i_obj_rd(rd), .i_obj_index(idx), .i_obj_wdata(wd), .o_obj_rdata(rdat),
    .o_obj_ack(ack), .o_obj_error(err), .i_self_test_ok(ok), .i_unrecoverable_error(unrec),
    .i_fault(flt), .i_fault_code(16'h1234), .i_limit_switch(lim), .i_standstill(still),
    .o_power_stage_on(pwr), .o_ramp_kind(rk), .o_halt_active(halt), .o_state_word(sw),
    .o_mode_display(md));
  task automatic wait_sw(input logic [15:0] e);
    for (int n = 0; n < 40 && sw !== e; n++) @(posedge i_clock);
    `CHK(sw, e)
  endtask : wait_sw
  task automatic go(input logic [15:0] cw, input logic [15:0] e);
    drive_master_i.access(1'b0, IDX_COMMAND, cw);
    // Let the decode edge pass so an unchanged word is not read too early
    @(posedge i_clock);
    wait_sw(e);
  endtask : go
  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // Generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge i_clock);
    `CHK(sw, SW_NOT_READY)
    i_rstn <= 1'b1;
    drive_master_i.access(1'b1, IDX_QS_CODE, 16'h0000);
    `CHK(drive_master_i.rdata_q, QS_CODE_RESET)
    drive_master_i.access(1'b1, IDX_SD_CODE, 16'h0000);
    `CHK(drive_master_i.rdata_q, SD_CODE_RESET)
    ok <= 1'b1;
    wait_sw(SW_SWITCH_ON_DISABLED);
    foreach (rows[i]) go(rows[i].cw, rows[i].sw);
    // Holding quick stop keeps the motor energized
    drive_master_i.access(1'b0, IDX_QS_CODE, CODE_QUICK_HOLD);
    for (int i = 0; i < 3; i++) go(rows[i].cw, rows[i].sw);
    go(16'h000B, SW_QUICK_STOP);
    repeat (6) @(posedge i_clock);
    `CHK(sw, SW_QUICK_STOP)
    `CHK(pwr, 1'b1)
    go(16'h000F, SW_OP_ENABLED);
    lim <= 1'b1;
    wait_sw(SW_QUICK_STOP);
    lim <= 1'b0;
    // Bit 2 stays high, so no edge and no return
    repeat (6) @(posedge i_clock);
    `CHK(sw, SW_QUICK_STOP)
    go(16'h0000, SW_SWITCH_ON_DISABLED);
    flt <= 1'b1;
    wait_sw(SW_FAULT);
    drive_master_i.access(1'b1, IDX_ERROR_CODE, 16'h0000);
    `CHK(drive_master_i.rdata_q, 16'h1234)
    flt <= 1'b0;
    go(16'h0080, SW_SWITCH_ON_DISABLED);
    drive_master_i.access(1'b0, IDX_MODE_SEL, 16'h0003);
    repeat (2) @(posedge i_clock);
    `CHK(md, 8'h03)
    drive_master_i.access(1'b1, IDX_STATE, 16'h0000);
    `CHK(drive_master_i.rdata_q, SW_SWITCH_ON_DISABLED)
    drive_master_i.access(1'b0, IDX_STATE, 16'h0006);
    `CHK(drive_master_i.err_q, 1'b1)
    drive_master_i.access(1'b1, 16'h7777, 16'h0000);
    `CHK(drive_master_i.err_q, 1'b1)
    for (int i = 0; i < 3; i++) go(rows[i].cw, rows[i].sw);
    go(16'h010F, SW_OP_ENABLED);
    `CHK(halt, 1'b1)
    `CHK(rk, RAMP_SLOW)
    // Standstill held low keeps the ramp running
    still <= 1'b0;
    go(16'h0007, SW_OP_ENABLED);
    `CHK(rk, RAMP_SLOW)
    `CHK(pwr, 1'b1)
    `CHK(halt, 1'b0)
    still <= 1'b1;
    wait_sw(SW_SWITCHED_ON);
    go(16'h000F, SW_OP_ENABLED);
    drive_master_i.access(1'b0, IDX_QS_CODE, CODE_NO_RAMP);
    go(16'h000B, SW_SWITCH_ON_DISABLED);
    `CHK(pwr, 1'b0)
    drive_master_i.access(1'b0, IDX_SD_CODE, CODE_NO_RAMP);
    for (int i = 0; i < 3; i++) go(rows[i].cw, rows[i].sw);
    still <= 1'b0;
    go(16'h0006, SW_READY);
    `CHK(pwr, 1'b0)
    still <= 1'b1;
    unrec <= 1'b1;
    wait_sw(SW_NOT_READY);
    unrec <= 1'b0;
    go(16'h0006, SW_NOT_READY);
    give_verdict();
  end
endmodule : tb
